// ---- design/ccpm_map.svh ----
`ifndef CCPM_MAP_SVH
`define CCPM_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define CCPM_IDX_FLAG_REG    8'h0c
`define CCPM_IDX_VALUE_LOW   8'h15
`define CCPM_IDX_VALUE_HIGH  8'h16
`define CCPM_IDX_CONTROL     8'h17

// ==========================================================
// field positions and reset values
`define CCPM_FLAG_BIT        2
`define CCPM_DUTY_LSB_HI     5
`define CCPM_DUTY_LSB_LO     4
`define CCPM_MODE_HI         3
`define CCPM_CTRL_RESET      6'h00
`define CCPM_VALUE_RESET     8'h00
`define CCPM_DUTY_LSB_RESET  2'h0
`define CCPM_RDATA_RESET     32'h0000_0000
`define CCPM_DUTY_ZERO       10'h000

// ==========================================================
// unit_mode_select codes
`define CCPM_MODE_OFF        4'h0
`define CCPM_MODE_CAP_FALL   4'h4
`define CCPM_MODE_CAP_R16    4'h7
`define CCPM_MODE_CMP_SET    4'h8
`define CCPM_MODE_CMP_CLR    4'h9
`define CCPM_MODE_CMP_SOFT   4'ha
`define CCPM_MODE_CMP_SPEC   4'hb
`define CCPM_MODE_PWM_TOP    2'b11

// ==========================================================
// capture prescaler
`define CCPM_SEL_FALL        2'h0
`define CCPM_SEL_RISE        2'h1
`define CCPM_SEL_R4          2'h2
`define CCPM_SEL_R16         2'h3
`define CCPM_PRESC_LAST4     2'h3
`define CCPM_PRESC_LAST16    4'hf
`define CCPM_PRESC_ONE       4'h1
`define CCPM_PRESC_CLEAR     4'h0

`endif

// ---- design/ccpm_pkg.sv ----
package ccpm_pkg;
  typedef enum logic [1:0] {
    CCPM_OFF,
    CCPM_CAPTURE,
    CCPM_COMPARE,
    CCPM_PWM
  } ccpm_func_t;
endpackage

// ---- design/ccpm_edge_scaler.sv ----
`include "ccpm_map.svh"

module ccpm_edge_scaler (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // control
  input  wire logic       enable,
  input  wire logic [1:0] edge_sel,
  // event level, already synchronised
  input  wire logic       event_level,
  // result
  output logic            capture_pulse
);
  import ccpm_pkg::*;

  logic       prev_level;
  logic [3:0] presc_count;
  logic       rise;
  logic       fall;

  assign rise = event_level & ~prev_level;
  assign fall = ~event_level & prev_level;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= event_level;
    end
  end

  // ==========================================================
  // prescaler: cleared only while not capturing, so a switch
  // between prescales keeps the count running
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      presc_count <= `CCPM_PRESC_CLEAR;
    end else if (!enable) begin
      presc_count <= `CCPM_PRESC_CLEAR;
    end else if (rise) begin
      presc_count <= presc_count + `CCPM_PRESC_ONE;
    end
  end

  always_comb begin
    capture_pulse = 1'b0;
    if (enable) begin
      case (edge_sel)
        `CCPM_SEL_FALL: capture_pulse = fall; // RL4
        `CCPM_SEL_RISE: capture_pulse = rise; // RL4
        `CCPM_SEL_R4:   capture_pulse = rise && (presc_count[1:0] == `CCPM_PRESC_LAST4); // RL4
        `CCPM_SEL_R16:  capture_pulse = rise && (presc_count == `CCPM_PRESC_LAST16); // RL5
        default:        capture_pulse = 1'b0;
      endcase
    end
  end

  // the count must wrap after a sixteenth-edge capture, or the next one comes late
  AST_R16_SPACING: assert property (@(posedge core_clk) disable iff (reset) // RL5
    (capture_pulse && edge_sel == `CCPM_SEL_R16) |->
      (presc_count == `CCPM_PRESC_LAST16) ##1 (presc_count == `CCPM_PRESC_CLEAR))
    else $error("sixteenth-edge capture out of step");

endmodule // ccpm_edge_scaler

// ---- design/ccpm_top.sv ----
// Notes on behaviour
// RL1 - value low/high and control are software read/write
// RL2 - first timer for capture/compare, second for PWM
// RL3 - mode field in control bits three to zero
// RL4 - capture on falling, rising, fourth, sixteenth rising
// RL5 - mode 0111 captures every sixteenth rising edge
// RL6 - mode 1000 drives output high on match
// RL7 - mode 1001 drives output low on match
// RL8 - soft compare mode only sets flag
// RL9 - mode 1011 flags and resets first timer
// RL10 - capture copies first timer count into value pair
// RL11 - capture sets flag bit two
// RL12 - flag cleared only by software
// RL13 - newer capture overwrites unread value
// RL14 - software should make pin an input
// RL15 - port write on output pin can capture
// RL16 - compare value pair with timer on update
// RL17 - special event starts conversion, no overflow flag
// RL18 - PWM duty from value low plus control bits
// RL19 - mode 0000 off; 0100/0101/0110 capture modes
// RL20 - upper mode bits 11 select PWM
// RL21 - reset clears control; bits seven, six read zero
`include "ccpm_map.svh"

module ccpm_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // first timer
  input  wire logic [15:0] first_timer_count,
  input  wire logic        first_timer_update,
  output logic             first_timer_reset,
  output logic             adc_start,
  // second timer
  input  wire logic [7:0]  second_timer_count,
  input  wire logic [1:0]  second_timer_fine,
  input  wire logic        second_timer_period_match,
  // port c bit shared with the unit
  input  wire logic        port_c_direction,
  input  wire logic        port_c_data,
  // capture_compare_pin
  input  wire logic        capture_compare_pin_in,
  output logic             capture_compare_pin_out,
  output logic             capture_compare_pin_oe,
  // flag
  output logic             capture_compare_flag
);
  import ccpm_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    reg_index = a[9:2];
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    addr_ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
              (idx == `CCPM_IDX_FLAG_REG || idx == `CCPM_IDX_VALUE_LOW ||
               idx == `CCPM_IDX_VALUE_HIGH || idx == `CCPM_IDX_CONTROL);
  endfunction

  function automatic ccpm_func_t decode_mode(input logic [3:0] m);
    if (m[3:2] == `CCPM_MODE_PWM_TOP)
      decode_mode = CCPM_PWM; // RL20
    else if (m[3])
      decode_mode = CCPM_COMPARE;
    else if (m[2])
      decode_mode = CCPM_CAPTURE; // RL19
    else
      decode_mode = CCPM_OFF; // RL19
  endfunction

  // ==========================================================
  // state
  logic [5:0] ccp_control;
  logic [7:0] ccp_value_low;
  logic [7:0] ccp_value_high;
  logic [1:0] duty_lsb_latch;
  logic       out_latch;
  logic       pin_sync1;
  logic       pin_sync2;
  logic       capture_pulse;
  logic       cmp_match;
  logic       wr;
  logic       setup;
  logic [7:0] wr_idx;
  logic [3:0] unit_mode_select;
  ccpm_func_t unit_func;

  assign unit_mode_select = ccp_control[`CCPM_MODE_HI:0]; // RL3
  assign unit_func        = decode_mode(unit_mode_select);
  assign wr               = psel && penable && pwrite;
  assign setup            = psel && !penable;
  assign wr_idx           = reg_index(paddr);
  assign pready           = 1'b1;

  // ==========================================================
  // pin input: two flops, then pick the level the unit watches
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= capture_compare_pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  // an output pin follows the port latch, so a port write looks like an edge
  logic event_level;
  assign event_level = port_c_direction ? pin_sync2 : port_c_data; // RL15 RL14

  ccpm_edge_scaler u_scaler (
    .core_clk      (core_clk),
    .reset         (reset),
    .enable        (unit_func == CCPM_CAPTURE),
    .edge_sel      (unit_mode_select[1:0]),
    .event_level   (event_level),
    .capture_pulse (capture_pulse)
  );

  // ==========================================================
  // compare against the first timer on every timer update
  assign cmp_match = (unit_func == CCPM_COMPARE) && first_timer_update &&
                     ({ccp_value_high, ccp_value_low} == first_timer_count); // RL16 RL2

  // ==========================================================
  // control register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ccp_control <= `CCPM_CTRL_RESET; // RL21
    end else if (wr && wr_idx == `CCPM_IDX_CONTROL) begin
      ccp_control <= pwdata[5:0]; // RL1
    end
  end

  // ==========================================================
  // value pair; a capture beats a same-cycle software write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ccp_value_low <= `CCPM_VALUE_RESET;
    end else if (capture_pulse) begin
      ccp_value_low <= first_timer_count[7:0]; // RL10 RL13
    end else if (wr && wr_idx == `CCPM_IDX_VALUE_LOW) begin
      ccp_value_low <= pwdata[7:0]; // RL1
    end
  end

  // in PWM mode the high byte is the duty buffer and ignores writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ccp_value_high <= `CCPM_VALUE_RESET;
      duty_lsb_latch <= `CCPM_DUTY_LSB_RESET;
    end else if (capture_pulse) begin
      ccp_value_high <= first_timer_count[15:8]; // RL10 RL13
    end else if (unit_func == CCPM_PWM) begin
      if (second_timer_period_match) begin
        ccp_value_high <= ccp_value_low; // RL18
        duty_lsb_latch <= ccp_control[`CCPM_DUTY_LSB_HI:`CCPM_DUTY_LSB_LO]; // RL18
      end
    end else if (wr && wr_idx == `CCPM_IDX_VALUE_HIGH) begin
      ccp_value_high <= pwdata[7:0]; // RL1
    end
  end

  // ==========================================================
  // flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      capture_compare_flag <= 1'b0;
    end else if (capture_pulse || cmp_match) begin
      capture_compare_flag <= 1'b1; // RL11 RL6 RL7 RL8 RL9
    end else if (wr && wr_idx == `CCPM_IDX_FLAG_REG) begin
      capture_compare_flag <= pwdata[`CCPM_FLAG_BIT]; // RL12
    end
  end

  // ==========================================================
  // output latch for compare and PWM
  logic [9:0] pwm_duty_next;
  assign pwm_duty_next = {ccp_value_low, ccp_control[`CCPM_DUTY_LSB_HI:`CCPM_DUTY_LSB_LO]};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_latch <= 1'b0;
    end else begin
      case (unit_func)
        CCPM_COMPARE: begin
          if (cmp_match && unit_mode_select == `CCPM_MODE_CMP_SET)
            out_latch <= 1'b1; // RL6
          else if (cmp_match && unit_mode_select == `CCPM_MODE_CMP_CLR)
            out_latch <= 1'b0; // RL7
        end
        CCPM_PWM: begin
          // period start wins; a duty above the period never clears
          if (second_timer_period_match)
            out_latch <= (pwm_duty_next != `CCPM_DUTY_ZERO); // RL2 RL18
          else if ({ccp_value_high, duty_lsb_latch} == {second_timer_count, second_timer_fine})
            out_latch <= 1'b0;
        end
        CCPM_OFF: out_latch <= 1'b0; // RL19
        default:  out_latch <= out_latch;
      endcase
    end
  end

  assign capture_compare_pin_out = (unit_func == CCPM_COMPARE || unit_func == CCPM_PWM) ?
                                   out_latch : port_c_data;
  assign capture_compare_pin_oe  = ~port_c_direction;

  // ==========================================================
  // special event: reset first timer and start a conversion;
  // the timer overflow flag is not touched from here
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      first_timer_reset <= 1'b0;
      adc_start         <= 1'b0;
    end else begin
      first_timer_reset <= cmp_match && unit_mode_select == `CCPM_MODE_CMP_SPEC; // RL9
      adc_start         <= cmp_match && unit_mode_select == `CCPM_MODE_CMP_SPEC; // RL17
    end
  end

  // ==========================================================
  // apb read data, sampled in the setup cycle so no wait state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata  <= `CCPM_RDATA_RESET;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !addr_ok(paddr);
      prdata  <= 32'h0000_0000;
      if (addr_ok(paddr)) begin
        case (reg_index(paddr))
          `CCPM_IDX_CONTROL:    prdata <= {26'h0, ccp_control}; // RL21 RL1
          `CCPM_IDX_VALUE_LOW:  prdata <= {24'h0, ccp_value_low};
          `CCPM_IDX_VALUE_HIGH: prdata <= {24'h0, ccp_value_high};
          `CCPM_IDX_FLAG_REG:   prdata <= {29'h0, capture_compare_flag, 2'h0}; // RL11
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  AST_CTRL_TOP_ZERO: assert property (@(posedge core_clk) disable iff (reset) // RL21
    (setup && !pwrite && paddr == {2'h0, `CCPM_IDX_CONTROL, 2'h0}) |=> (prdata[7:6] == 2'h0))
    else $error("control bits seven and six not zero");

  AST_CAPTURE_COPY: assert property (@(posedge core_clk) disable iff (reset) // RL10
    capture_pulse |=> ({ccp_value_high, ccp_value_low} == $past(first_timer_count)))
    else $error("capture did not copy timer count");

  AST_CAPTURE_FLAG: assert property (@(posedge core_clk) disable iff (reset) // RL11
    (capture_pulse && !$past(capture_pulse)) |=> capture_compare_flag [*1])
    else $error("capture did not set flag");

  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (reset) // RL12
    (capture_compare_flag && !(wr && wr_idx == `CCPM_IDX_FLAG_REG)) |=> capture_compare_flag)
    else $error("flag cleared without software");

  AST_CMP_SET: assert property (@(posedge core_clk) disable iff (reset) // RL6
    (cmp_match && unit_mode_select == `CCPM_MODE_CMP_SET) |=> (out_latch && capture_compare_flag))
    else $error("set-on-match failed");

  AST_CMP_CLR: assert property (@(posedge core_clk) disable iff (reset) // RL7
    (cmp_match && unit_mode_select == `CCPM_MODE_CMP_CLR) |=> (!out_latch && capture_compare_flag))
    else $error("clear-on-match failed");

  AST_CMP_SOFT: assert property (@(posedge core_clk) disable iff (reset) // RL8
    (cmp_match && unit_mode_select == `CCPM_MODE_CMP_SOFT) |=> ($stable(out_latch) && capture_compare_flag))
    else $error("soft compare touched the pin");

  AST_SPECIAL: assert property (@(posedge core_clk) disable iff (reset) // RL9
    (cmp_match && unit_mode_select == `CCPM_MODE_CMP_SPEC) |=> (first_timer_reset && adc_start))
    else $error("special event missing");

  AST_NO_STRAY_EVENT: assert property (@(posedge core_clk) disable iff (reset) // RL17
    first_timer_reset |-> $past(cmp_match))
    else $error("timer reset without match");

  AST_OFF_LOW: assert property (@(posedge core_clk) disable iff (reset) // RL19
    (unit_mode_select == `CCPM_MODE_OFF) |=> !out_latch)
    else $error("output latch not low when off");

  AST_PWM_BUFFER: assert property (@(posedge core_clk) disable iff (reset) // RL18
    (unit_func == CCPM_PWM && second_timer_period_match && !capture_pulse)
      |=> (ccp_value_high == $past(ccp_value_low)))
    else $error("duty not latched at period end");

  COV_CAPTURE_R16: cover property (@(posedge core_clk) disable iff (reset)
    capture_pulse && unit_mode_select == `CCPM_MODE_CAP_R16);
  COV_CAPTURE_FALL: cover property (@(posedge core_clk) disable iff (reset)
    capture_pulse && unit_mode_select == `CCPM_MODE_CAP_FALL);
  COV_SPECIAL: cover property (@(posedge core_clk) disable iff (reset) first_timer_reset);
  COV_PWM_HIGH: cover property (@(posedge core_clk) disable iff (reset)
    unit_func == CCPM_PWM && out_latch);

endmodule // ccpm_top

// ---- test/ccpm_pin_src.sv ----
module ccpm_pin_src (
  // clock
  input  wire logic core_clk,
  // event line toward the capture pin
  output logic      pad
);
  timeunit 1ns;
  timeprecision 1ns;

  initial pad = 1'h0;

  // ==========================================================
  // level steps
  // the pin is synchronised, so each level is held 5 cycles;
  // edges closer than 1 cycle would be lost
  task automatic level(input logic v);
    @(posedge core_clk);
    pad <= v;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      level(1'h1);
      level(1'h0);
    end
  endtask
endmodule // ccpm_pin_src

// ---- test/tb.sv ----
`include "ccpm_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ccpm_pkg::*;

  localparam logic [11:0] A_FLAG = {2'h0, `CCPM_IDX_FLAG_REG, 2'h0};
  localparam logic [11:0] A_LOW  = {2'h0, `CCPM_IDX_VALUE_LOW, 2'h0};
  localparam logic [11:0] A_HIGH = {2'h0, `CCPM_IDX_VALUE_HIGH, 2'h0};
  localparam logic [11:0] A_CTRL = {2'h0, `CCPM_IDX_CONTROL, 2'h0};

  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] first_timer_count;
  logic        first_timer_update, first_timer_reset, adc_start;
  logic [7:0]  second_timer_count;
  logic [1:0]  second_timer_fine;
  logic        second_timer_period_match, port_c_direction, port_c_data;
  logic        capture_compare_pin_in, capture_compare_pin_out;
  logic        capture_compare_pin_oe, capture_compare_flag;
  int          n_fail, checked;
  logic [3:0]  cm [4] = '{4'h8, 4'ha, 4'h9, 4'hb};
  logic        cp [4] = '{1'h1, 1'h1, 1'h0, 1'h0};
  logic        ct [4] = '{1'h0, 1'h0, 1'h0, 1'h1};

  ccpm_top DUT (
    .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .first_timer_count, .first_timer_update, .first_timer_reset, .adc_start,
    .second_timer_count, .second_timer_fine, .second_timer_period_match,
    .port_c_direction, .port_c_data, .capture_compare_pin_in,
    .capture_compare_pin_out, .capture_compare_pin_oe, .capture_compare_flag
  );

  ccpm_pin_src src (
    .core_clk (core_clk),
    .pad      (capture_compare_pin_in)
  );

  initial core_clk = 1'h0;
  always #10 core_clk = ~core_clk;

  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      n_fail++;
      final_report();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic        e;
    apb(1'h1, a, x, d, e);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic        e;
    apb(1'h0, a, 32'h0, d, e);
    chk(nm, d, x);
  endtask

  // one timer update pulse carrying value v
  task automatic tick(input logic [15:0] v);
    @(posedge core_clk);
    first_timer_count <= v;
    first_timer_update <= 1'h1;
    @(posedge core_clk);
    first_timer_update <= 1'h0;
    #1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic        e;
    logic [3:0]  md;
    int          n;
    n_fail = 0;
    checked = 0;
    reset = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {first_timer_count, first_timer_update, port_c_data} = '0;
    {second_timer_count, second_timer_fine, second_timer_period_match} = '0;
    port_c_direction = 1'h1;
    repeat (5) @(posedge core_clk);
    reset <= 1'h0;
    rdc("ctrl reset", A_CTRL, 32'h0);
    rdc("low reset", A_LOW, 32'h0);
    chk("pin oe input", capture_compare_pin_oe, 32'h0);
    wr(A_CTRL, 32'hff);
    rdc("ctrl rw", A_CTRL, 32'h3f);
    wr(A_CTRL, 32'h0);
    wr(A_LOW, 32'ha5);
    wr(A_HIGH, 32'h5a);
    rdc("low rw", A_LOW, 32'ha5);
    rdc("high rw", A_HIGH, 32'h5a);
    apb(1'h0, 12'h040, 32'h0, d, e);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", d, 32'h0);
    // capture modes; control cleared first so the prescaler starts at zero
    for (int m = 4; m < 8; m++) begin
      md = m[3:0];
      n = (md == 4'h6) ? 4 : (md == 4'h7) ? 16 : 1;
      wr(A_CTRL, 32'h0);
      wr(A_CTRL, {28'h0, md});
      wr(A_FLAG, 32'h0);
      first_timer_count <= {4'h1, md, 8'h5a};
      if (md == 4'h4) src.level(1'h1);
      else src.pulses(n - 1);
      #1 chk("flag early", capture_compare_flag, 32'h0);
      if (md == 4'h4) src.level(1'h0);
      else src.pulses(1);
      #1 chk("flag", capture_compare_flag, 32'h1);
      rdc("cap low", A_LOW, 32'h5a);
      rdc("cap high", A_HIGH, {28'h1, md});
      rdc("flag reg", A_FLAG, 32'h4);
    end
    // reserved code 0001 below the capture range must behave as off
    wr(A_CTRL, 32'h1);
    wr(A_FLAG, 32'h0);
    src.pulses(1);
    #1 chk("reserved mode", capture_compare_flag, 32'h0);
    wr(A_CTRL, 32'h05);
    wr(A_FLAG, 32'h0);
    first_timer_count <= 16'h4321;
    src.pulses(1);
    first_timer_count <= 16'h8765;
    src.pulses(1);
    repeat (20) @(posedge core_clk);
    #1 chk("flag held", capture_compare_flag, 32'h1);
    rdc("over low", A_LOW, 32'h65);
    rdc("over high", A_HIGH, 32'h87);
    wr(A_FLAG, 32'h0);
    port_c_direction <= 1'h0;
    first_timer_count <= 16'h0777;
    repeat (3) @(posedge core_clk);
    port_c_data <= 1'h1;
    repeat (6) @(posedge core_clk);
    #1 chk("port write cap", capture_compare_flag, 32'h1);
    chk("pin oe output", capture_compare_pin_oe, 32'h1);
    chk("pin follows port", capture_compare_pin_out, 32'h1);
    rdc("port cap low", A_LOW, 32'h77);
    // compare modes in an order that shows the unchanged-pin cases
    wr(A_CTRL, 32'h0);
    port_c_data <= 1'h0;
    wr(A_LOW, 32'h5a);
    wr(A_HIGH, 32'h3c);
    wr(A_CTRL, 32'h08);
    wr(A_FLAG, 32'h0);
    first_timer_count <= 16'h3c5a;
    tick(16'h3c5b);
    chk("no match", capture_compare_flag, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, {28'h0, cm[i]});
      wr(A_FLAG, 32'h0);
      tick(16'h3c5a);
      chk("cmp flag", capture_compare_flag, 32'h1);
      chk("cmp pin", capture_compare_pin_out, {31'h0, cp[i]});
      chk("timer reset", first_timer_reset, {31'h0, ct[i]});
      chk("adc start", adc_start, {31'h0, ct[i]});
      @(posedge core_clk);
      #1 chk("trig end", first_timer_reset, 32'h0);
    end
    // pwm: duty {0x02, 2'b01}, lsbs must matter for the clear point
    for (int i = 0; i < 2; i++) begin
      wr(A_CTRL, 32'h0);
      wr(A_LOW, 32'h02);
      wr(A_CTRL, i ? 32'h1f : 32'h1c);
      second_timer_count <= 8'h00;
      second_timer_fine <= 2'h0;
      second_timer_period_match <= 1'h1;
      @(posedge core_clk);
      second_timer_period_match <= 1'h0;
      second_timer_count <= 8'h02;
      repeat (2) @(posedge core_clk);
      #1 chk("pwm set", capture_compare_pin_out, 32'h1);
      rdc("pwm duty", A_HIGH, 32'h02);
      second_timer_fine <= 2'h1;
      repeat (2) @(posedge core_clk);
      #1 chk("pwm clear", capture_compare_pin_out, 32'h0);
    end
    final_report();
  end
endmodule // tb
